// ==== inc/spc_pkg.sv ====
package spc_pkg;
    localparam int    POS_W         = 16;
    localparam int    SEC_W         = 11;
    localparam int    SEC_LSB       = 5;
    localparam int    ADDR_W        = 5;
    localparam int    VMAX_W        = 4;
    localparam int    CLK_MHZ       = 125;
    localparam int    UPDATE_US     = 1024;
    localparam int    UPDATE_CYC    = UPDATE_US * CLK_MHZ;
    localparam int    STEP_CYC_DEF  = 64;
    localparam logic [4:0] OTP_ADDR_RST = 5'h00;
    localparam logic [15:0] VEL_OFFSET = 16'h7fff;

    typedef enum logic [3:0] {
        SPC_CMD_NONE    = 4'h0,
        SPC_CMD_STATUS1 = 4'h1,
        SPC_CMD_STATUS2 = 4'h2,
        SPC_CMD_SETPOS  = 4'h3,
        SPC_CMD_INIT    = 4'h4,
        SPC_CMD_STOP    = 4'h5,
        SPC_CMD_CLRPOS  = 4'h6,
        SPC_CMD_OTP     = 4'h7,
        SPC_CMD_PARAM   = 4'h8
    } spc_cmd_t;

    typedef enum logic [1:0] {
        SPC_MV_IDLE  = 2'b00,
        SPC_MV_RUN   = 2'b01,
        SPC_MV_INIT1 = 2'b10,
        SPC_MV_INIT2 = 2'b11
    } spc_move_t;

    localparam logic [1:0] MODE_HALF = 2'h0;
    localparam logic [1:0] MODE_Q    = 2'h1;
    localparam logic [1:0] MODE_8    = 2'h2;
    localparam logic [1:0] MODE_16   = 2'h3;
endpackage

// ==== inc/spc_link_if.sv ====
`timescale 1ns/100ps
interface spc_link_if;
    logic                          reqValid;
    logic                          reqReady;
    logic [spc_pkg::ADDR_W-1:0]    reqAddr;
    logic                          reqHw;
    spc_pkg::spc_cmd_t             reqCmd;
    logic [15:0]                   reqArgA;
    logic [15:0]                   reqArgB;
    logic                          rspValid;
    logic [31:0]                   rspData;

    modport ctrl (output reqValid, reqAddr, reqHw, reqCmd, reqArgA, reqArgB,
                  input reqReady, rspValid, rspData);
    modport dev  (input reqValid, reqAddr, reqHw, reqCmd, reqArgA, reqArgB,
                  output reqReady, rspValid, rspData);
endinterface

// ==== design/spc_stepper.sv ====
`timescale 1ns/100ps
module spc_stepper #(
    parameter int STEP_CYC = spc_pkg::STEP_CYC_DEF
) (
    // Clock and reset.
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    // Target and control.
    input  wire logic [15:0]              target,
    input  wire logic                     run,
    input  wire logic [1:0]               stepMode,
    input  wire logic                     loadZero,
    // Position.
    output logic      [15:0]              position,
    output logic                          atTarget
);
    typedef struct packed {
        logic [15:0] pos;
        logic [31:0] cnt;
    } spc_step_st_t;
    spc_step_st_t sQ, sD;
    logic [15:0] diff;
    logic [15:0] inc;

    always_comb begin
        sD = sQ;
        // Mode picks the weight of one step, read live so a change hits the running move.
        inc = 16'h0001 << (2'h3 - stepMode); // [RULE_13] [RULE_16]
        diff = target - sQ.pos; // [RULE_17]
        if (loadZero) begin
            sD.pos = 16'h0000;
            sD.cnt = '0;
        end else if (run && diff != 16'h0000) begin // [RULE_19]
            if (sQ.cnt >= 32'(STEP_CYC - 1)) begin
                sD.cnt = '0;
                // Wraparound arithmetic plus sign of the difference gives the short way.
                if (diff[15]) begin // [RULE_17]
                    sD.pos = (16'h0000 - diff) < inc ? target : sQ.pos - inc;
                end else begin
                    sD.pos = diff < inc ? target : sQ.pos + inc;
                end
            end else begin
                sD.cnt = sQ.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sQ <= '0;
        end else begin
            sQ <= sD;
        end
    end

    assign position = sQ.pos;
    assign atTarget = (sQ.pos == target);
endmodule

// ==== design/spc_device.sv ====
`timescale 1ns/100ps
// Function
// [RULE_01] Answer only own node address.
// [RULE_02] Fresh part physical address reads zero.
// [RULE_03] Address pin joins address match.
// [RULE_04] Defect flag is OR of coil faults.
// [RULE_05] Each coil fault set by own coil.
// [RULE_06] Switch never steers any state machine.
// [RULE_07] Host polls switch via status one.
// [RULE_08] Direction bit selects rotation sense.
// [RULE_09] No interrupt; host polls motion state.
// [RULE_10] Switch in status one, position status two.
// [RULE_11] Init second target reached clears position.
// [RULE_12] Velocity changes stay within one group.
// [RULE_13] Step mode change applies immediately.
// [RULE_14] Host emulates velocity mode by retargeting.
// [RULE_15] Positions two's complement, sixteenth steps.
// [RULE_16] Effective LSB moves with step mode.
// [RULE_17] Circular position, shortest way moved.
// [RULE_18] Secure position is upper eleven bits.
// [RULE_19] Motion runs until counter reaches target.
// [RULE_20] Switch flag one when driven, zero floating.
// [RULE_21] Switch flag sampled with position periodically.
// [RULE_22] Stop halts; clear zeroes both positions.
// [RULE_23] Host keeps init targets distinct.
module spc_device #(
    parameter int UPDATE_CYC = spc_pkg::UPDATE_CYC,
    parameter int STEP_CYC   = spc_pkg::STEP_CYC_DEF
) (
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // Link to the controller.
    spc_link_if.dev           link,
    // Switch pin sensed as driven high and driven low.
    input  wire logic         switchHigh,
    input  wire logic         switchLow,
    // Coil fault events.
    input  wire logic         coilAOver,
    input  wire logic         coilAOpen,
    input  wire logic         coilBOver,
    input  wire logic         coilBOpen,
    // Motor direction and step outputs.
    output logic              dirCw,
    output logic [15:0]       coilPhase
);
    typedef struct packed {
        logic [4:0]  otpAddr;
        logic        hwStrap;
        logic [15:0] target;
        logic [15:0] target2;
        spc_pkg::spc_move_t mv;
        logic [1:0]  stepMode;
        logic        shaft;
        logic [3:0]  vmax;
        logic        faultA;
        logic        faultB;
        logic        swFlag;
        logic [15:0] posSnap;
        logic [31:0] tick;
        logic [1:0]  swS1;
        logic [1:0]  swS2;
        logic [3:0]  fltS1;
        logic [3:0]  fltS2;
        logic        rspValid;
        logic [31:0] rspData;
    } spc_dev_st_t;
    spc_dev_st_t sQ, sD;
    logic [15:0] actual_position;
    logic        atTarget;
    logic        hit;
    logic        loadZero;
    logic        elecDefect;
    logic [10:0] securePos;
    // Field positions of the parameter word in the first argument.
    localparam int SHAFT_BIT = spc_pkg::VMAX_W;
    localparam int MODE_LSB  = spc_pkg::VMAX_W + 1;

    spc_stepper #(.STEP_CYC(STEP_CYC)) uStep (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .target   (sQ.target),
        .run      (sQ.mv != spc_pkg::SPC_MV_IDLE),
        .stepMode (sQ.stepMode),
        .loadZero (loadZero),
        .position (actual_position),
        .atTarget (atTarget)
    );

    assign elecDefect = sQ.faultA | sQ.faultB; // [RULE_04]
    assign securePos  = actual_position[15:spc_pkg::SEC_LSB]; // [RULE_18]
    assign hit = link.reqValid && link.reqAddr == sQ.otpAddr // [RULE_01]
                 && link.reqHw == sQ.hwStrap; // [RULE_03]
    assign loadZero = (hit && link.reqCmd == spc_pkg::SPC_CMD_CLRPOS) // [RULE_22]
                      || (sQ.mv == spc_pkg::SPC_MV_INIT2 && atTarget); // [RULE_11]

    always_comb begin
        sD = sQ;
        sD.rspValid = 1'b0;
        sD.swS1 = {sQ.swS1[0], switchHigh};
        sD.swS2 = {sQ.swS2[0], switchLow};
        // Fault events come from the analog driver, so they pass two flops first.
        sD.fltS1 = {coilAOver, coilAOpen, coilBOver, coilBOpen};
        sD.fltS2 = sQ.fltS1;
        sD.faultA = sQ.faultA | sQ.fltS2[3] | sQ.fltS2[2]; // [RULE_05]
        sD.faultB = sQ.faultB | sQ.fltS2[1] | sQ.fltS2[0]; // [RULE_05]
        // Switch flag and position snapshot share one update tick.
        if (sQ.tick >= 32'(UPDATE_CYC - 1)) begin // [RULE_21]
            sD.tick = '0;
            sD.swFlag = sQ.swS1[1] | sQ.swS2[1]; // [RULE_20]
            sD.posSnap = actual_position;
        end else begin
            sD.tick = sQ.tick + 32'h1;
        end
        case (sQ.mv)
            spc_pkg::SPC_MV_RUN: begin
                if (atTarget) begin
                    sD.mv = spc_pkg::SPC_MV_IDLE; // [RULE_19]
                end
            end
            spc_pkg::SPC_MV_INIT1: begin
                if (atTarget) begin
                    sD.target = sQ.target2;
                    sD.mv = spc_pkg::SPC_MV_INIT2;
                end
            end
            spc_pkg::SPC_MV_INIT2: begin
                if (atTarget) begin
                    // Target and position both go to zero on one edge, so nothing moves on.
                    sD.target = 16'h0000; // [RULE_11]
                    sD.mv = spc_pkg::SPC_MV_IDLE;
                end
            end
            default: begin
                sD.mv = spc_pkg::SPC_MV_IDLE;
            end
        endcase
        // Switch state is never consulted below; it only reaches status one.
        if (hit) begin // [RULE_06]
            case (link.reqCmd)
                // No interrupt pin exists; motion state is read back here.
                spc_pkg::SPC_CMD_STATUS1: begin
                    sD.rspValid = 1'b1;
                    sD.rspData = {5'h00, securePos, // [RULE_18]
                                  sQ.swFlag, elecDefect, sQ.faultA, sQ.faultB, // [RULE_10]
                                  sQ.shaft, sQ.stepMode, 3'h0, sQ.vmax, // [RULE_12]
                                  sQ.mv}; // [RULE_09]
                    // The read clears the flags, but an event in the same cycle survives.
                    sD.faultA = sQ.fltS2[3] | sQ.fltS2[2];
                    sD.faultB = sQ.fltS2[1] | sQ.fltS2[0];
                end
                spc_pkg::SPC_CMD_STATUS2: begin
                    sD.rspValid = 1'b1;
                    sD.rspData = {sQ.posSnap, sQ.target}; // [RULE_10] [RULE_15]
                end
                spc_pkg::SPC_CMD_SETPOS: begin
                    // A set defect flag blocks new position moves, not init runs, until status one clears it.
                    if (!elecDefect) begin
                        sD.target = link.reqArgA; // [RULE_15]
                        sD.mv = spc_pkg::SPC_MV_RUN;
                    end
                end
                spc_pkg::SPC_CMD_INIT: begin
                    sD.target = link.reqArgA;
                    sD.target2 = link.reqArgB;
                    sD.mv = spc_pkg::SPC_MV_INIT1;
                end
                spc_pkg::SPC_CMD_STOP: begin
                    sD.mv = spc_pkg::SPC_MV_IDLE; // [RULE_22]
                    // Parking the target on the live position keeps the stepper from resuming.
                    sD.target = actual_position;
                end
                spc_pkg::SPC_CMD_CLRPOS: begin
                    sD.target = 16'h0000; // [RULE_22]
                    sD.mv = spc_pkg::SPC_MV_IDLE;
                end
                spc_pkg::SPC_CMD_PARAM: begin
                    // Velocity groups are the host's duty; the index is stored and read back.
                    sD.vmax = link.reqArgA[spc_pkg::VMAX_W-1:0]; // [RULE_12]
                    sD.shaft = link.reqArgA[SHAFT_BIT]; // [RULE_08]
                    sD.stepMode = link.reqArgA[MODE_LSB+:2]; // [RULE_13]
                end
                spc_pkg::SPC_CMD_OTP: begin
                    // Programming only sets bits, as a fuse would.
                    sD.otpAddr = sQ.otpAddr | link.reqArgA[spc_pkg::ADDR_W-1:0];
                end
                default: begin
                    sD.rspValid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sQ <= '0;
            // Reset also drops programmed address bits, unlike a real fuse array.
            sQ.otpAddr <= spc_pkg::OTP_ADDR_RST; // [RULE_02]
            sQ.stepMode <= spc_pkg::MODE_16;
        end else begin
            sQ <= sD;
        end
    end

    assign link.reqReady = 1'b1;
    assign link.rspValid = sQ.rspValid;
    assign link.rspData  = sQ.rspData;
    assign dirCw     = sQ.shaft; // [RULE_08]
    assign coilPhase = sQ.shaft ? actual_position : 16'h0000 - actual_position;
endmodule

// ==== design/spc_controller.sv ====
`timescale 1ns/100ps
module spc_controller (
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // Wishbone slave.
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [3:0]   wb_adr_i,
    input  wire logic [31:0]  wb_dat_i,
    input  wire logic [3:0]   wb_sel_i,
    output logic              wb_ack_o,
    output logic [31:0]       wb_dat_o,
    // Link to the device.
    spc_link_if.ctrl          link
);
    localparam logic [3:0] REG_CMD  = 4'h0;
    localparam logic [3:0] REG_ARG  = 4'h4;
    localparam logic [3:0] REG_RSP  = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hc;
    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic        pend;
        logic [3:0]  cmd;
        logic [4:0]  addr;
        logic        hw;
        logic [31:0] arg;
        logic [31:0] rsp;
        logic        rspNew;
    } spc_ctl_st_t;
    spc_ctl_st_t sQ, sD;
    logic req;

    assign req = wb_cyc_i && wb_stb_i && !sQ.ack;
    always_comb begin
        sD = sQ;
        sD.ack = req;
        if (link.rspValid) begin
            sD.rsp = link.rspData; // [RULE_07] [RULE_09]
            sD.rspNew = 1'b1;
        end
        if (sQ.pend && link.reqReady) begin
            sD.pend = 1'b0;
        end
        if (req) begin
            case (wb_adr_i)
                REG_CMD: sD.rdat = {21'h0, sQ.hw, sQ.addr, sQ.cmd, sQ.pend};
                REG_ARG: sD.rdat = sQ.arg;
                REG_RSP: sD.rdat = sQ.rsp;
                REG_STAT: sD.rdat = {31'h0, sQ.rspNew};
                default: sD.rdat = 32'h0;
            endcase
            if (wb_we_i && wb_adr_i == REG_CMD && wb_sel_i[1:0] == 2'h3) begin
                sD.cmd  = wb_dat_i[3:0];
                sD.addr = wb_dat_i[8:4]; // [RULE_01]
                sD.hw   = wb_dat_i[9]; // [RULE_03]
                sD.pend = 1'b1;
            end
            if (wb_we_i && wb_adr_i == REG_ARG) begin
                sD.arg = wb_dat_i;
            end
            if (!wb_we_i && wb_adr_i == REG_RSP && !link.rspValid) begin
                sD.rspNew = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sQ <= '0;
        end else begin
            sQ <= sD;
        end
    end

    assign wb_ack_o      = sQ.ack;
    assign wb_dat_o      = sQ.rdat;
    assign link.reqValid = sQ.pend;
    assign link.reqAddr  = sQ.addr;
    assign link.reqHw    = sQ.hw;
    assign link.reqCmd   = spc_pkg::spc_cmd_t'(sQ.cmd);
    assign link.reqArgA  = sQ.arg[15:0]; // [RULE_14]
    assign link.reqArgB  = sQ.arg[31:16]; // [RULE_23]
endmodule

// ==== verif/spc_link_monitor.sv ====
`timescale 1ns/100ps
module spc_link_monitor (
    // Clock and reset.
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    // Link signals.
    input  wire logic                       reqValid,
    input  wire logic [spc_pkg::ADDR_W-1:0] reqAddr,
    input  wire logic                       reqHw,
    input  wire spc_pkg::spc_cmd_t          reqCmd,
    input  wire logic [15:0]                reqArgA,
    input  wire logic                       rspValid,
    input  wire logic [31:0]                rspData
);
    typedef struct packed {
        logic       clr;
        logic       shaft;
        logic [1:0] mode;
        logic [4:0] node;
    } spc_mon_t;
    spc_mon_t st_q;
    spc_mon_t st_d;
    logic     mine;
    // A fresh part answers at node zero; programming only adds address bits.
    assign mine = reqValid && reqAddr == st_q.node && !reqHw;
    always_comb begin
        st_d = st_q;
        if (mine && reqCmd == spc_pkg::SPC_CMD_PARAM) begin
            st_d.shaft = reqArgA[4];
            st_d.mode  = reqArgA[6:5];
        end
        if (mine && reqCmd == spc_pkg::SPC_CMD_OTP)
            st_d.node = st_q.node | reqArgA[4:0];
        if (mine && reqCmd == spc_pkg::SPC_CMD_CLRPOS)
            st_d.clr = 1'b1;
        if (mine && (reqCmd == spc_pkg::SPC_CMD_SETPOS || reqCmd == spc_pkg::SPC_CMD_INIT))
            st_d.clr = 1'b0;
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            st_q <= '{clr: 1'b0, shaft: 1'b0, mode: 2'h3, node: 5'h00};
        else
            st_q <= st_d;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence statusTake;
        mine && (reqCmd == spc_pkg::SPC_CMD_STATUS1 || reqCmd == spc_pkg::SPC_CMD_STATUS2);
    endsequence
    sequence status1Take;
        mine && reqCmd == spc_pkg::SPC_CMD_STATUS1;
    endsequence
    sequence status2Take;
        mine && reqCmd == spc_pkg::SPC_CMD_STATUS2;
    endsequence
    chk_status_answered:
        assert property (statusTake |=> rspValid) else $error("status request unanswered");
    chk_foreign_silent:
        assert property (reqValid && reqAddr != st_q.node |=> !rspValid)
        else $error("foreign answer");
    chk_hw_pin_match:
        assert property (reqValid && reqHw |=> !rspValid) else $error("strap mismatch answered");
    chk_answer_cause:
        assert property (rspValid |-> $past(mine) && ($past(reqCmd) == spc_pkg::SPC_CMD_STATUS1
            || $past(reqCmd) == spc_pkg::SPC_CMD_STATUS2)) else $error("answer without request");
    chk_defect_or:
        assert property (status1Take |=> rspData[14] == (rspData[13] | rspData[12]))
        else $error("defect flag not OR of coil flags");
    chk_shaft_field:
        assert property (status1Take |=> rspData[11] == st_q.shaft) else $error("shaft bit wrong");
    chk_mode_field:
        assert property (status1Take |=> rspData[10:9] == st_q.mode) else $error("step mode wrong");
    chk_clear_target:
        assert property (status2Take and st_q.clr |=> rspData[15:0] == 16'h0000)
        else $error("target not cleared");
endmodule

// ==== verif/stepper_position_controller_test.sv ====
`timescale 1ns/100ps
module stepper_position_controller_test;
    logic        clk_sys;
    logic        sys_rst    = 1'b1;
    logic        wbCyc      = 1'b0;
    logic        wbStb      = 1'b0;
    logic        wbWe       = 1'b0;
    logic [3:0]  wbAdr      = 4'h0;
    logic [31:0] wbDatW     = 32'h0;
    logic [3:0]  wbSel      = 4'hf;
    logic        wbAck;
    logic [31:0] wbDatR;
    logic        switchHigh = 1'b0;
    logic        switchLow  = 1'b0;
    logic [3:0]  coilFault  = 4'h0;
    logic        dirCw;
    int          fails      = 0;
    int          totalChecks = 0;
    spc_link_if link ();
    spc_device #(.UPDATE_CYC(16), .STEP_CYC(4)) spc_device_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.dev), .switchHigh(switchHigh),
        .switchLow(switchLow), .coilAOver(coilFault[3]), .coilAOpen(coilFault[2]),
        .coilBOver(coilFault[1]), .coilBOpen(coilFault[0]), .dirCw(dirCw), .coilPhase());
    spc_controller spc_controller_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel),
        .wb_ack_o(wbAck), .wb_dat_o(wbDatR), .link(link.ctrl));
    spc_link_monitor spc_link_monitor_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(link.reqValid),
        .reqAddr(link.reqAddr), .reqHw(link.reqHw), .reqCmd(link.reqCmd),
        .reqArgA(link.reqArgA), .rspValid(link.rspValid), .rspData(link.rspData));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    // The request is held until ack is seen at an edge; the bound only guards a hang.
    task automatic wb_cycle(input logic [3:0] adr, input logic we, input logic [31:0] wd,
                            output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= wd;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 50) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic send(input logic hw, input logic [4:0] adr, input spc_pkg::spc_cmd_t c,
                        input logic [15:0] a, input logic [15:0] b);
        logic [31:0] d;
        wb_cycle(4'h4, 1'b1, {b, a}, d);
        wb_cycle(4'h0, 1'b1, {22'h0, hw, adr, c}, d);
    endtask
    task automatic status(input logic hw, input logic [4:0] adr, input spc_pkg::spc_cmd_t c,
                          output logic got, output logic [31:0] rsp);
        logic [31:0] s;
        got = 1'b0;
        rsp = 32'h0;
        send(hw, adr, c, 16'h0000, 16'h0000);
        for (int i = 0; i < 8 && !got; i++) begin
            wb_cycle(4'hc, 1'b0, 32'h0, s);
            got = (s[0] === 1'b1);
        end
        if (got)
            wb_cycle(4'h8, 1'b0, 32'h0, rsp);
    endtask
    task automatic wait_idle();
        logic        g;
        logic [31:0] r;
        r = 32'h1;
        for (int i = 0; i < 300 && r[1:0] !== 2'b00; i++)
            status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
        check("motion idle", 32'h4, {29'h0, g, r[1:0]});
        if (r[1:0] !== 2'b00)
            tally_and_finish();
        // Two and a half update periods so the position snapshot has caught up.
        repeat (40) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        logic        g;
        logic [31:0] r;
        wb_cycle(4'h2, 1'b0, 32'h0, r);
        check("unmapped read", 32'h0, r);
        status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
        check("status1 after reset", 32'h0000_0600, r & 32'h0000_fe03);
        $display("t_reset done");
    endtask
    task automatic t_address();
        logic        g;
        logic [31:0] r;
        status(1'b0, 5'h05, spc_pkg::SPC_CMD_STATUS1, g, r);
        check("foreign node answered", 32'h0, {31'h0, g});
        status(1'b1, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
        check("strap mismatch answered", 32'h0, {31'h0, g});
        $display("t_address done");
    endtask
    task automatic t_faults();
        logic        g;
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            coilFault <= 4'h8 >> i;
            @(posedge clk_sys);
            coilFault <= 4'h0;
            status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
            check("coil flags", (i < 2) ? 32'h6 : 32'h5, {29'h0, r[14:12]});
            status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
            check("coil flags cleared", 32'h0, {29'h0, r[14:12]});
        end
        $display("t_faults done");
    endtask
    task automatic t_switch();
        logic        g;
        logic [31:0] r;
        logic [2:0]  tbl [3];
        tbl = '{3'b101, 3'b011, 3'b000};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            {switchHigh, switchLow} <= tbl[i][2:1];
            repeat (40) @(posedge clk_sys);
            status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
            check("switch flag", {31'h0, tbl[i][0]}, {31'h0, r[15]});
            check("motion with switch", 32'h0, {30'h0, r[1:0]});
        end
        $display("t_switch done");
    endtask
    task automatic t_move();
        logic        g;
        logic [31:0] r;
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_CLRPOS, 16'h0000, 16'h0000);
        // Minus sixteen is reached only in time if the short way back is taken.
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_SETPOS, 16'hfff0, 16'h0000);
        wait_idle();
        status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS2, g, r);
        check("position minus 16", 32'hfff0, {16'h0, r[31:16]});
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_SETPOS, 16'h0100, 16'h0000);
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_PARAM, 16'h0011, 16'h0000);
        // At half steps the move ends long before it would at sixteenths.
        repeat (200) @(posedge clk_sys);
        status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
        check("half step move done", 32'h0, {30'h0, r[1:0]});
        check("vmax field", 32'h1, {28'h0, r[5:2]});
        check("secure position", 32'h008, {21'h0, r[26:16]});
        wait_idle();
        check("direction pin", 32'h1, {31'h0, dirCw});
        status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS2, g, r);
        check("position half step", 32'h0100, {16'h0, r[31:16]});
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_PARAM, 16'h0061, 16'h0000);
        $display("t_move done");
    endtask
    task automatic t_init_stop();
        logic        g;
        logic [31:0] r;
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_INIT, 16'h0040, 16'h0080);
        wait_idle();
        status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS2, g, r);
        check("position after init", 32'h0, {16'h0, r[31:16]});
        // Position is zero here, so its low 16 bits plus the offset is the offset.
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_SETPOS, spc_pkg::VEL_OFFSET, 16'h0000);
        repeat (20) @(posedge clk_sys);
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_STOP, 16'h0000, 16'h0000);
        status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
        check("motion after stop", 32'h0, {30'h0, r[1:0]});
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_CLRPOS, 16'h0000, 16'h0000);
        repeat (40) @(posedge clk_sys);
        status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS2, g, r);
        check("positions cleared", 32'h0, r);
        $display("t_init_stop done");
    endtask
    task automatic t_otp();
        logic        g;
        logic [31:0] r;
        send(1'b0, 5'h00, spc_pkg::SPC_CMD_OTP, 16'h0003, 16'h0000);
        status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
        check("old node answered", 32'h0, {31'h0, g});
        status(1'b0, 5'h03, spc_pkg::SPC_CMD_STATUS1, g, r);
        check("new node answered", 32'h1, {31'h0, g});
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        status(1'b0, 5'h00, spc_pkg::SPC_CMD_STATUS1, g, r);
        check("status1 after second reset", 32'h0000_0600, r & 32'h0000_fe03);
        $display("t_otp done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_address();
        t_faults();
        t_switch();
        t_move();
        t_init_stop();
        t_otp();
        tally_and_finish();
    end
endmodule
